// ===== shared/bcr_pkg.sv
package bcr_pkg;

    // Configuration byte offsets of the header registers
    localparam logic [7:0]  CAP_HEAD_OFF     = 8'h34;
    localparam logic [7:0]  IRQ_LINE_OFF     = 8'h3c;
    localparam logic [7:0]  IRQ_PIN_OFF      = 8'h3d;
    localparam logic [7:0]  BCTRL_OFF        = 8'h3e;

    // Values after reset and fixed read values
    localparam logic [7:0]  CAP_HEAD_VALUE   = 8'h88;
    localparam logic [7:0]  IRQ_LINE_RESET   = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VALUE    = 8'h01;
    localparam logic [15:0] BCTRL_RESET      = 16'h0000;

    // Bridge control field positions
    localparam int          BCTRL_VGA_EN_BIT = 3;
    localparam int          BCTRL_VGA16_BIT  = 4;
    localparam int          BCTRL_MASTER_ABORT_BEHAVIOR_BIT = 5;
    localparam int          BCTRL_HOTRST_BIT = 6;
    localparam int          BCTRL_FB2B_BIT   = 7;

    // Only the hot reset, VGA 16-bit decode and VGA enable bits store
    localparam logic [15:0] BCTRL_WR_MASK    = 16'h0058;

    // Data returned for a read that ends in master abort
    localparam logic [31:0] MABORT_RD_DATA   = 32'hffff_ffff;
    localparam logic [31:0] CFG_ZERO_DATA    = 32'h0000_0000;

    // Legacy VGA ranges
    localparam logic [9:0]  VGA_IO_A_LO      = 10'h3b0;
    localparam logic [9:0]  VGA_IO_A_HI      = 10'h3bb;
    localparam logic [9:0]  VGA_IO_B_LO      = 10'h3c0;
    localparam logic [9:0]  VGA_IO_B_HI      = 10'h3df;
    localparam logic [31:0] VGA_MEM_LO       = 32'h000a_0000;
    localparam logic [31:0] VGA_MEM_HI       = 32'h000b_ffff;

endpackage : bcr_pkg

// ===== shared/bcr_dec_if.sv
interface bcr_dec_if;

    // Access to classify and the routing controls that steer it
    logic [31:0] addr;
    logic        is_io;
    logic        vga_en;
    logic        vga16;
    logic        vga_hit;

    modport requester (
        output addr,
        output is_io,
        output vga_en,
        output vga16,
        input  vga_hit
    );

    modport decoder (
        input  addr,
        input  is_io,
        input  vga_en,
        input  vga16,
        output vga_hit
    );

endinterface : bcr_dec_if

// ===== logic/bcr_vga_decode.sv
module bcr_vga_decode
    import bcr_pkg::*;
(
    // Decode channel
    bcr_dec_if.decoder dec
);

    logic [9:0] io_low;
    logic       io_in_range;
    logic       io_alias_ok;
    logic       io_upper_ok;
    logic       mem_in_range;

    // Legacy range comparison
    always_comb begin
        io_low       = dec.addr[9:0];
        io_in_range  = ((io_low >= VGA_IO_A_LO) && (io_low <= VGA_IO_A_HI)) ||
                       ((io_low >= VGA_IO_B_LO) && (io_low <= VGA_IO_B_HI)); // R9
        io_alias_ok  = !dec.vga16 || (dec.addr[15:10] == 6'h00); // R9
        io_upper_ok  = (dec.addr[31:16] == 16'h0000);
        mem_in_range = (dec.addr >= VGA_MEM_LO) && (dec.addr <= VGA_MEM_HI);
    end

    // 16-bit selection only matters once VGA routing is on
    always_comb begin
        if (!dec.vga_en) begin
            dec.vga_hit = 1'b0; // R10 R11
        end else if (dec.is_io) begin
            dec.vga_hit = io_in_range && io_alias_ok && io_upper_ok; // R10
        end else begin
            dec.vga_hit = mem_in_range; // R11
        end
    end

endmodule : bcr_vga_decode

// ===== logic/bcr_header_regs.sv
// Function
// R1 - The capability list head reads as the fixed value 88h.
// R2 - The interrupt line register is an 8-bit read/write store, reset to 00h, with no effect.
// R3 - The interrupt pin register reads as the fixed value 01h, meaning INTA.
// R4 - Bridge control bits 11 to 8 (discard timer controls) read as zero.
// R5 - Bridge control bit 7 (fast back-to-back enable) reads as zero.
// R6 - Bridge control bit 6 set to one drives a hot reset on the port; zero drives none.
// R7 - Bridge control bit 5 reads as zero and master-aborted reads return all ones.
// R8 - Master-aborted writes complete normally and their data is discarded.
// R9 - Bridge control bit 4 selects 10-bit (aliased) or 16-bit VGA I/O decode.
// R10 - The 16-bit decode selection only acts while the VGA enable bit 3 is set.
// R11 - The VGA enable bit, reset to zero, routes VGA I/O and memory accesses to the port.
// R12 - Bridge control bits 15 to 12 read as zero and ignore writes.
module bcr_header_regs
    import bcr_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,

    // Configuration access
    input  wire logic        cfg_wr_en,
    input  wire logic        cfg_rd_en,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rd_valid,

    // Processor access routing
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_is_io,
    output logic             route_valid,
    output logic             route_to_pcie,

    // Master abort completion
    input  wire logic        mabort_valid,
    input  wire logic        mabort_is_read,
    output logic             cpl_valid,
    output logic             cpl_is_read,
    output logic      [31:0] cpl_data,

    // Port controls
    output logic             secondary_hot_reset,
    output logic             vga_route_enable
);

    // Dword hit test, shared by read and write paths
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
        dword_hit = (addr[7:2] == off[7:2]);
    endfunction : dword_hit

    // Register state
    logic [7:0]  irq_routing_value_reg;
    logic [7:0]  irq_routing_value_next;
    logic [15:0] bridge_control_reg;
    logic [15:0] bridge_control_next;
    logic [31:0] cfg_rdata_reg;
    logic [31:0] cfg_rdata_next;
    logic        cfg_rd_valid_reg;
    logic        cfg_rd_valid_next;

    // Routing and completion state
    logic        route_valid_reg;
    logic        route_valid_next;
    logic        route_to_pcie_reg;
    logic        route_to_pcie_next;
    logic        cpl_valid_reg;
    logic        cpl_valid_next;
    logic        cpl_is_read_reg;
    logic        cpl_is_read_next;
    logic [31:0] cpl_data_reg;
    logic [31:0] cpl_data_next;

    // Assembled read words
    logic [31:0] cap_word;
    logic [31:0] irq_word;
    logic [15:0] bctrl_wr_value;

    bcr_dec_if dec_ch ();

    // VGA range decoder
    bcr_vga_decode u_vga_decode (
        .dec (dec_ch.decoder)
    );

    // Decoder inputs from live control bits
    assign dec_ch.addr   = acc_addr;
    assign dec_ch.is_io  = acc_is_io;
    assign dec_ch.vga_en = bridge_control_reg[BCTRL_VGA_EN_BIT]; // R10 R11
    assign dec_ch.vga16  = bridge_control_reg[BCTRL_VGA16_BIT];  // R9

    // Read words per dword
    always_comb begin
        cap_word = {24'h00_0000, CAP_HEAD_VALUE}; // R1
        irq_word = {bridge_control_reg, IRQ_PIN_VALUE, irq_routing_value_reg}; // R2 R3
    end

    // Configuration register next values
    always_comb begin
        irq_routing_value_next = irq_routing_value_reg;
        bridge_control_next    = bridge_control_reg;
        bctrl_wr_value         = {cfg_be[3] ? cfg_wdata[31:24] : bridge_control_reg[15:8],
                                  cfg_be[2] ? cfg_wdata[23:16] : bridge_control_reg[7:0]};
        if (cfg_wr_en && dword_hit(cfg_addr, IRQ_LINE_OFF)) begin
            if (cfg_be[0]) begin
                irq_routing_value_next = cfg_wdata[7:0]; // R2
            end
            // Only three bits store; the rest stay zero
            bridge_control_next = bctrl_wr_value & BCTRL_WR_MASK; // R4 R5 R7 R12
        end
    end

    // Configuration read next values
    always_comb begin
        cfg_rd_valid_next = cfg_rd_en;
        cfg_rdata_next    = cfg_rdata_reg;
        if (cfg_rd_en) begin
            if (dword_hit(cfg_addr, CAP_HEAD_OFF)) begin
                cfg_rdata_next = cap_word; // R1
            end else if (dword_hit(cfg_addr, IRQ_LINE_OFF)) begin
                cfg_rdata_next = irq_word; // R3 R12
            end else begin
                cfg_rdata_next = CFG_ZERO_DATA;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_routing_value_reg <= IRQ_LINE_RESET;
            bridge_control_reg    <= BCTRL_RESET;
            cfg_rdata_reg         <= CFG_ZERO_DATA;
            cfg_rd_valid_reg      <= 1'b0;
        end else if (ce) begin
            irq_routing_value_reg <= irq_routing_value_next;
            bridge_control_reg    <= bridge_control_next;
            cfg_rdata_reg         <= cfg_rdata_next;
            cfg_rd_valid_reg      <= cfg_rd_valid_next;
        end
    end

    // Routing decision next values
    always_comb begin
        route_valid_next   = acc_valid;
        route_to_pcie_next = route_to_pcie_reg;
        if (acc_valid) begin
            route_to_pcie_next = dec_ch.vga_hit; // R9 R10 R11
        end
    end

    // Routing decision registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            route_valid_reg   <= 1'b0;
            route_to_pcie_reg <= 1'b0;
        end else if (ce) begin
            route_valid_reg   <= route_valid_next;
            route_to_pcie_reg <= route_to_pcie_next;
        end
    end

    // Master abort completion next values
    always_comb begin
        cpl_valid_next   = mabort_valid;
        cpl_is_read_next = cpl_is_read_reg;
        cpl_data_next    = cpl_data_reg;
        if (mabort_valid) begin
            cpl_is_read_next = mabort_is_read;
            if (mabort_is_read) begin
                cpl_data_next = MABORT_RD_DATA; // R7
            end else begin
                cpl_data_next = CFG_ZERO_DATA; // R8
            end
        end
    end

    // Master abort completion registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpl_valid_reg   <= 1'b0;
            cpl_is_read_reg <= 1'b0;
            cpl_data_reg    <= CFG_ZERO_DATA;
        end else if (ce) begin
            cpl_valid_reg   <= cpl_valid_next;
            cpl_is_read_reg <= cpl_is_read_next;
            cpl_data_reg    <= cpl_data_next;
        end
    end

    // Outputs straight from flops
    assign cfg_rdata           = cfg_rdata_reg;
    assign cfg_rd_valid        = cfg_rd_valid_reg;
    assign route_valid         = route_valid_reg;
    assign route_to_pcie       = route_to_pcie_reg;
    assign cpl_valid           = cpl_valid_reg;
    assign cpl_is_read         = cpl_is_read_reg;
    assign cpl_data            = cpl_data_reg;
    assign secondary_hot_reset = bridge_control_reg[BCTRL_HOTRST_BIT]; // R6
    assign vga_route_enable    = bridge_control_reg[BCTRL_VGA_EN_BIT]; // R11

endmodule : bcr_header_regs

// ===== verif/bcr_header_regs_props.sv
module bcr_header_regs_props
    import bcr_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // Configuration access
    input wire logic        cfg_wr_en,
    input wire logic        cfg_rd_en,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rd_valid,
    // Routing and completion
    input wire logic        acc_valid,
    input wire logic        route_valid,
    input wire logic        route_to_pcie,
    input wire logic        mabort_valid,
    input wire logic        mabort_is_read,
    input wire logic        cpl_valid,
    input wire logic        cpl_is_read,
    input wire logic [31:0] cpl_data,
    // Port controls
    input wire logic        secondary_hot_reset,
    input wire logic        vga_route_enable
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Accesses to the header dword
    wire rd_hdr = ce && cfg_rd_en && cfg_addr[7:2] == 6'h0f;
    wire wr_ctl = ce && cfg_wr_en && cfg_addr[7:2] == 6'h0f && cfg_be[2];
    cap_head_a: assert property (
        ce && cfg_rd_en && cfg_addr[7:2] == 6'h0d |=> cfg_rd_valid && cfg_rdata == 32'h0000_0088)
        else $error("capability head read wrong");
    pin_code_a: assert property (rd_hdr |=> cfg_rd_valid && cfg_rdata[15:8] == 8'h01)
        else $error("interrupt pin read wrong");
    ro_zero_a: assert property (
        rd_hdr |=> cfg_rdata[31:23] == 9'h000 && !cfg_rdata[21] && cfg_rdata[18:16] == 3'h0)
        else $error("read-only control bits not zero");
    hot_reset_a: assert property (wr_ctl |=> secondary_hot_reset == $past(cfg_wdata[22]))
        else $error("hot reset does not follow write");
    vga_enable_a: assert property (wr_ctl |=> vga_route_enable == $past(cfg_wdata[19]))
        else $error("route enable does not follow write");
    ctl_hold_a: assert property (
        !wr_ctl |=> $stable(secondary_hot_reset) && $stable(vga_route_enable))
        else $error("control output moved without write");
    abort_read_a: assert property (
        ce && mabort_valid && mabort_is_read |=> cpl_valid && cpl_is_read && cpl_data == 32'hffff_ffff)
        else $error("aborted read completion wrong");
    abort_write_a: assert property (
        ce && mabort_valid && !mabort_is_read |=> cpl_valid && !cpl_is_read && cpl_data == 32'h0)
        else $error("aborted write completion wrong");
    route_off_a: assert property (
        ce && acc_valid && !vga_route_enable |=> route_valid && !route_to_pcie)
        else $error("routed while disabled");
    // Main scenarios reached
    hot_seen_c: cover property ($rose(secondary_hot_reset));
    route_seen_c: cover property (route_valid && route_to_pcie);
    abort_seen_c: cover property (cpl_valid && cpl_is_read);
endmodule : bcr_header_regs_props

bind bcr_header_regs bcr_header_regs_props u_bcr_header_regs_props (.*);

// ===== verif/bcr_header_regs_tb.sv
module bcr_header_regs_tb
    import bcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, ce, cfg_wr_en, cfg_rd_en, acc_valid, acc_is_io;
    logic        mabort_valid, mabort_is_read, cfg_rd_valid, route_valid, route_to_pcie;
    logic        cpl_valid, cpl_is_read, secondary_hot_reset, vga_route_enable;
    logic [7:0]  cfg_addr, line_m;
    logic [3:0]  cfg_be;
    logic [15:0] bctrl_m;
    logic [31:0] cfg_wdata, cfg_rdata, acc_addr, cpl_data;
    int          n_fail, num_checks;
    logic [7:0]  adr_tab[4] = '{8'h34, 8'h3c, 8'h3e, 8'h20};
    logic [31:0] cor_tab[12] = '{32'h3b0, 32'h3bb, 32'h3bc, 32'h3c0, 32'h3df, 32'h3e0,
        32'h7c0, 32'h103c0, 32'ha0000, 32'hbffff, 32'h9ffff, 32'hc0000};

    // Device under test
    bcr_header_regs u_bcr_header_regs (.*);

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Expected read data from the bench's register copy
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a[7:2])
            6'h0d:   return 32'h0000_0088;
            6'h0f:   return {bctrl_m, 8'h01, line_m};
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    // Expected routing decision
    function automatic logic exp_rt(input logic [31:0] a, input logic io);
        logic hit;
        hit = (a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) || (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df);
        if (!bctrl_m[3]) return 1'b0;
        if (!io) return a >= 32'h000a_0000 && a <= 32'h000b_ffff;
        return hit && a[31:16] == 16'h0 && (!bctrl_m[4] || a[15:10] == 6'h0);
    endfunction : exp_rt

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        cfg_wr_en <= 1'b1;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr_en <= 1'b0;
        if (ce && a[7:2] == 6'h0f && be[0]) line_m = d[7:0];
        if (ce && a[7:2] == 6'h0f && be[2]) bctrl_m[7:0] = d[23:16] & 8'h58;
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] a);
        @(posedge clk);
        cfg_rd_en <= 1'b1;
        cfg_addr  <= a;
        @(posedge clk);
        cfg_rd_en <= 1'b0;
        #1;
        chk(cfg_rd_valid, 1'b1);
        chk(cfg_rdata, exp_rd(a));
    endtask : cfg_rd

    task automatic acc(input logic [31:0] a, input logic io);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr  <= a;
        acc_is_io <= io;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
        chk(route_valid, 1'b1);
        chk(route_to_pcie, exp_rt(a, io));
    endtask : acc

    task automatic mab(input logic rd);
        @(posedge clk);
        mabort_valid   <= 1'b1;
        mabort_is_read <= rd;
        @(posedge clk);
        mabort_valid <= 1'b0;
        #1;
        chk({cpl_valid, cpl_is_read}, {1'b1, rd});
        chk(cpl_data, rd ? 32'hffff_ffff : 32'h0000_0000);
    endtask : mab

    // Hang guard
    initial begin
        #100us;
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {sys_rst, ce} = 2'b11;
        {cfg_wr_en, cfg_rd_en, acc_valid, acc_is_io, mabort_valid, mabort_is_read} = '0;
        {cfg_addr, cfg_be, cfg_wdata, acc_addr, line_m, bctrl_m} = '0;
        {n_fail, num_checks} = '0;
        void'($urandom(32'h7a6c));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        cfg_rd(8'h34);
        cfg_rd(8'h3c);
        cfg_rd(8'h20);
        cfg_wr(8'h34, 4'hf, 32'h0000_0000);
        cfg_rd(8'h34);
        cfg_wr(8'h3c, 4'hf, 32'hffff_ffff);
        cfg_rd(8'h3c);
        repeat (30) begin
            cfg_wr(adr_tab[$urandom_range(3)], 4'($urandom), $urandom);
            cfg_rd(8'h3c);
            chk({secondary_hot_reset, vga_route_enable}, {bctrl_m[6], bctrl_m[3]});
        end
        for (int m = 0; m < 4; m++) begin
            cfg_wr(8'h3e, 4'h4, {8'h00, 3'b000, m[1], m[0], 3'b000, 16'h0000});
            foreach (cor_tab[i]) begin
                acc(cor_tab[i], 1'b1);
                acc(cor_tab[i], 1'b0);
            end
            repeat (10) acc($urandom & 32'h000f_ffff, 1'($urandom));
        end
        mab(1'b1);
        mab(1'b0);
        @(posedge clk);
        ce <= 1'b0;
        cfg_wr(8'h3c, 4'h4, ~{bctrl_m, 16'h0000});
        ce <= 1'b1;
        cfg_rd(8'h3c);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        {line_m, bctrl_m} = '0;
        cfg_rd(8'h3c);
        tally_and_finish();
    end
endmodule : bcr_header_regs_tb
